// >>> hdl/secf_pkg.sv
// Purpose: shared constants, types and decoders of the serial memory front end
// Assumes: sys_clk at 200 MHz; sck is the host's serial clock
// Notes:   all timing counts derive from printed times
//
// What this block does
// - link runs only in clock modes (0,0) and (1,1).
// - input bits are sampled on the rising serial clock edge.
// - output bits change on the falling serial clock edge.
// - chip select high floats output; running write cycle still completes.
// - write-protect pin high never blocks a write.
// - pin low with protect enable set refuses status register writes.
// - hold freezes transfer state; transfer resumes at the same bit.
// - first eight bits of a session form the instruction byte.
// - only six opcodes act; any other byte is ignored for the session.
// - opcode 03 hex is memory read.
// - opcode 02 hex is memory write.
// - 06 write enable, 04 write disable, 05 status read, 01 status write.
// - memory write needs opcode, address, data and a set enable latch.
// - write cycle starts at chip select rise, lasts at most 5 ms.
// - write enable sets the latch, write disable clears it.
// - during a write cycle only status read is accepted.
// - status byte: protect enable 7, block bits 3:2, latch 1, busy 0.
// - read takes a 16-bit address, data follows the last address bit.

package secf_pkg;

  // opcodes
  localparam logic [7:0] OPC_WRITE_EN  = 8'h06;
  localparam logic [7:0] OPC_WRITE_DIS = 8'h04;
  localparam logic [7:0] OPC_STAT_RD   = 8'h05;
  localparam logic [7:0] OPC_STAT_WR   = 8'h01;
  localparam logic [7:0] OPC_MEM_RD    = 8'h03;
  localparam logic [7:0] OPC_MEM_WR    = 8'h02;

  // field sizes and positions
  localparam int          MEM_AW        = 14;
  localparam logic [3:0]  LAST_ADDR_BIT = 4'hF;
  localparam logic [3:0]  LAST_BYTE_BIT = 4'h7;
  localparam int          SR_PEN_BIT    = 7;
  localparam int          SR_BPH_BIT    = 3;
  localparam int          SR_BPL_BIT    = 2;
  localparam logic [7:0]  SR_BUSY_BYTE  = 8'hFF;
  localparam logic [13:0] QUARTER_BASE  = 14'h3000;
  localparam logic [13:0] HALF_BASE     = 14'h2000;

  // reset values of the status bits
  localparam logic       PEN_RST = 1'b0;
  localparam logic [1:0] BP_RST  = 2'b00;

  // write cycle time, longest figure rounds down
  localparam int SYS_CLK_KHZ   = 200000;
  localparam int WRITE_TIME_MS = 5;
  localparam int WRITE_CYCLES  = WRITE_TIME_MS * SYS_CLK_KHZ;

  typedef enum logic [2:0] {
    CMD_NONE, CMD_CMD_WRITE_ENABLE, CMD_CMD_WRITE_DISABLE, CMD_CMD_STATUS_READ, CMD_CMD_STATUS_WRITE, CMD_READ, CMD_WRITE
  } secf_cmd_t;

  typedef enum logic [2:0] {
    PH_OPC, PH_ADDR, PH_DIN, PH_DOUT, PH_IGNORE
  } secf_phase_t;

  typedef struct packed {
    logic protect_pin_enable;
    logic block_protect_hi;
    logic block_protect_lo;
    logic write_enable_latch;
    logic busy;
  } secf_status_t;

  typedef struct packed {
    logic              valid;
    logic [MEM_AW-1:0] addr;
    logic [7:0]        data;
  } secf_mem_wr_t;

  // opcode decode
  function automatic secf_cmd_t secf_decode(input logic [7:0] op);
    case (op)
      OPC_WRITE_EN:  secf_decode = CMD_CMD_WRITE_ENABLE;
      OPC_WRITE_DIS: secf_decode = CMD_CMD_WRITE_DISABLE;
      OPC_STAT_RD:   secf_decode = CMD_CMD_STATUS_READ;
      OPC_STAT_WR:   secf_decode = CMD_CMD_STATUS_WRITE;
      OPC_MEM_RD:    secf_decode = CMD_READ;
      OPC_MEM_WR:    secf_decode = CMD_WRITE;
      default:       secf_decode = CMD_NONE;
    endcase
  endfunction

  // status byte as shifted out; all ones while busy
  function automatic logic [7:0] secf_status_byte(input secf_status_t st);
    if (st.busy)
      secf_status_byte = SR_BUSY_BYTE;
    else
      secf_status_byte = {st.protect_pin_enable, 3'h0, st.block_protect_hi,
                          st.block_protect_lo, st.write_enable_latch, 1'b0};
  endfunction

  // block protection by address
  function automatic logic secf_blocked(input logic [1:0] bp, input logic [MEM_AW-1:0] a);
    case (bp)
      2'h1:    secf_blocked = (a >= QUARTER_BASE);
      2'h2:    secf_blocked = (a >= HALF_BASE);
      2'h3:    secf_blocked = 1'b1;
      default: secf_blocked = 1'b0;
    endcase
  endfunction

endpackage

// >>> hdl/secf_sync.sv
// Purpose: two-flop level synchroniser, any width
// Assumes: each bit is a level or quasi-static word bit
// Notes:   first stage feeds only the second stage
`timescale 1ns/100ps
`default_nettype none

module secf_sync
  import secf_pkg::*;
#(
  parameter int W = 1
) (
  // clock and reset
  input  wire  logic         clk,
  input  wire  logic         rst,
  // levels
  input  wire  logic [W-1:0] d,
  output logic       [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } secf_sync_state_t;

  secf_sync_state_t st_reg;
  secf_sync_state_t st_next;

  // shift through both stages
  always_comb begin
    st_next.s1 = d;
    st_next.s2 = st_reg.s1;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign q = st_reg.s2;

endmodule // secf_sync
`default_nettype wire

// >>> hdl/secf_wtimer.sv
// Purpose: self-timed write cycle counter
// Assumes: start is a one-cycle pulse on sys_clk
// Notes:   a start while busy is dropped
`timescale 1ns/100ps
`default_nettype none

module secf_wtimer
  import secf_pkg::*;
#(
  parameter int CYCLES = WRITE_CYCLES
) (
  // clock and reset
  input  wire  logic sys_clk,
  input  wire  logic rst,
  // control
  input  wire  logic start,
  output logic       busy,
  output logic       done
);

  localparam int CW = $clog2(CYCLES + 1);

  typedef struct packed {
    logic          busy;
    logic          done;
    logic [CW-1:0] cnt;
  } secf_tmr_state_t;

  secf_tmr_state_t st_reg;
  secf_tmr_state_t st_next;

  // count down the whole write cycle
  always_comb begin
    st_next      = st_reg;
    st_next.done = 1'b0;
    if (!st_reg.busy) begin
      if (start) begin
        st_next.busy = 1'b1;
        st_next.cnt  = CW'(CYCLES - 1);
      end
    end else if (st_reg.cnt == '0) begin
      st_next.busy = 1'b0;
      st_next.done = 1'b1;
    end else begin
      st_next.cnt = st_reg.cnt - 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign busy = st_reg.busy;
  assign done = st_reg.done;

endmodule // secf_wtimer
`default_nettype wire

// >>> hdl/secf_frontend.sv
// Purpose: serial command front end of a byte-wide nonvolatile memory
// Assumes: memory array answers mem_rd_data combinationally from mem_rd_addr
// Notes:   only the first data byte of a memory write is kept
`timescale 1ns/100ps
`default_nettype none

module secf_frontend
  import secf_pkg::*;
#(
  parameter int WRITE_CYC = WRITE_CYCLES
) (
  // system clock and reset
  input  wire  logic              sys_clk,
  input  wire  logic              rst,
  // serial pins
  input  wire  logic              sck,
  input  wire  logic              cs_n,
  input  wire  logic              si,
  input  wire  logic              hold_n,
  input  wire  logic              wp_n,
  output logic                    so,
  output logic                    so_oe_n,
  // memory array
  output logic       [MEM_AW-1:0] mem_rd_addr,
  input  wire  logic [7:0]        mem_rd_data,
  output secf_mem_wr_t            mem_wr,
  // status
  output secf_status_t            status
);

  // ---------------------------------------------------------------
  // link side state (sck domain)
  // ---------------------------------------------------------------
  typedef struct packed {
    secf_phase_t       ph;
    logic [3:0]        cnt;
    logic [7:0]        opc;
    logic [15:0]       addr;
    logic [7:0]        din;
    secf_cmd_t         cmd;
    secf_cmd_t         act;
    logic              seq;
    logic [MEM_AW-1:0] rd_addr;
    logic              rd_status;
  } secf_link_t;

  typedef struct packed {
    logic so;
    logic oe_n;
  } secf_out_t;

  // ---------------------------------------------------------------
  // system side state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic         cs_prev;
    logic         seq_seen;
    secf_status_t st;
    secf_mem_wr_t wr;
  } secf_sys_t;

  secf_link_t   lk_reg;
  secf_link_t   lk_next;
  secf_out_t    out_reg;
  secf_out_t    out_next;
  secf_sys_t    sy_reg;
  secf_sys_t    sy_next;
  logic         fresh_reg;
  secf_status_t st_sck;
  logic         cs_s;
  logic         wp_s;
  logic         seq_s;
  logic         tmr_busy;
  logic         tmr_done;
  logic         tmr_start;
  secf_phase_t  ph;
  logic [3:0]   cnt;
  secf_cmd_t    dec;
  logic [7:0]   out_byte;

  // status into the sck domain; quasi-static inside a frame
  secf_sync #(.W(5)) u_sync_sck (
    .clk (sck),
    .rst (rst),
    .d   (sy_reg.st),
    .q   (st_sck)
  );

  // pins and the commit toggle into the sys domain
  secf_sync #(.W(3)) u_sync_sys (
    .clk (sys_clk),
    .rst (rst),
    .d   ({cs_n, wp_n, lk_reg.seq}),
    .q   ({cs_s, wp_s, seq_s})
  );

  secf_wtimer #(.CYCLES(WRITE_CYC)) u_wtimer (
    .sys_clk (sys_clk),
    .rst     (rst),
    .start   (tmr_start),
    .busy    (tmr_busy),
    .done    (tmr_done)
  );

  // ---------------------------------------------------------------
  // frame start marker
  // ---------------------------------------------------------------
  // set while deselected, cleared by the first live rising edge;
  // the sck may stand still between frames, so cs_n does the reset
  always_ff @(posedge sck or posedge cs_n) begin
    if (cs_n) begin
      fresh_reg <= 1'b1;
    end else if (hold_n) begin
      fresh_reg <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // receive and decode on the rising edge
  // ---------------------------------------------------------------
  always_comb begin
    lk_next = lk_reg;
    ph      = fresh_reg ? PH_OPC : lk_reg.ph;
    cnt     = fresh_reg ? 4'h0 : lk_reg.cnt;
    dec     = secf_decode({lk_reg.opc[6:0], si});
    if (hold_n) begin
      lk_next.ph  = ph;
      lk_next.cnt = cnt + 4'h1;
      case (ph)
        PH_OPC: begin
          lk_next.opc = {lk_reg.opc[6:0], si};
          if (cnt == LAST_BYTE_BIT) begin
            lk_next.cnt = 4'h0;
            lk_next.cmd = dec;
            lk_next.ph  = PH_IGNORE;
            if (!st_sck.busy || dec == CMD_CMD_STATUS_READ) begin
              case (dec)
                CMD_CMD_WRITE_ENABLE, CMD_CMD_WRITE_DISABLE: begin
                  lk_next.act = dec;
                  lk_next.seq = ~lk_reg.seq;
                end
                CMD_CMD_STATUS_READ: begin
                  lk_next.ph        = PH_DOUT;
                  lk_next.rd_status = 1'b1;
                end
                CMD_CMD_STATUS_WRITE: begin
                  lk_next.ph = PH_DIN;
                end
                CMD_READ, CMD_WRITE: begin
                  lk_next.ph        = PH_ADDR;
                  lk_next.rd_status = 1'b0;
                end
                default: begin
                  lk_next.ph = PH_IGNORE;
                end
              endcase
            end
          end
        end
        PH_ADDR: begin
          lk_next.addr = {lk_reg.addr[14:0], si};
          if (cnt == LAST_ADDR_BIT) begin
            lk_next.cnt = 4'h0;
            if (lk_reg.cmd == CMD_READ) begin
              lk_next.ph      = PH_DOUT;
              lk_next.rd_addr = lk_next.addr[MEM_AW-1:0];
            end else begin
              lk_next.ph = PH_DIN;
            end
          end
        end
        PH_DIN: begin
          lk_next.din = {lk_reg.din[6:0], si};
          if (cnt == LAST_BYTE_BIT) begin
            // extra bytes are dropped, no page buffer here
            lk_next.ph  = PH_IGNORE;
            lk_next.act = lk_reg.cmd;
            lk_next.seq = ~lk_reg.seq;
          end
        end
        PH_DOUT: begin
          if (cnt == LAST_BYTE_BIT) begin
            lk_next.cnt = 4'h0;
            if (!lk_reg.rd_status) begin
              lk_next.rd_addr = lk_reg.rd_addr + 1'b1;
            end
          end
        end
        default: begin
          lk_next.cnt = lk_reg.cnt;
        end
      endcase
    end
  end

  // act and words are not cleared by cs_n: sys side reads them after the frame
  always_ff @(posedge sck or posedge rst) begin
    if (rst) begin
      lk_reg <= '{ph: PH_IGNORE, act: CMD_NONE, cmd: CMD_NONE, default: '0};
    end else begin
      lk_reg <= lk_next;
    end
  end

  // ---------------------------------------------------------------
  // drive the output on the falling edge
  // ---------------------------------------------------------------
  always_comb begin
    out_byte = lk_reg.rd_status ? secf_status_byte(st_sck) : mem_rd_data;
    out_next = out_reg;
    // mode (1,1) opens with a falling edge before any bit: stay floating
    if (fresh_reg) begin
      out_next.oe_n = 1'b1;
    end else begin
      out_next.oe_n = (lk_reg.ph != PH_DOUT);
      out_next.so   = out_byte[~lk_reg.cnt[2:0]];
    end
  end

  always_ff @(negedge sck or posedge cs_n) begin
    if (cs_n) begin
      out_reg <= '{so: 1'b0, oe_n: 1'b1};
    end else begin
      out_reg <= out_next;
    end
  end

  // ---------------------------------------------------------------
  // commit at chip select rise (sys domain)
  // ---------------------------------------------------------------
  // the toggle tells a new command from a repeat of an old one;
  // act, din and addr stand still long before cs_s rises
  always_comb begin
    sy_next          = sy_reg;
    sy_next.cs_prev  = cs_s;
    sy_next.wr.valid = 1'b0;
    tmr_start        = 1'b0;
    if (cs_s && !sy_reg.cs_prev && seq_s != sy_reg.seq_seen) begin
      sy_next.seq_seen = seq_s;
      // registered busy also spans the done cycle, so no commit
      // meets the end-of-cycle latch clear or a stale latch
      if (!sy_reg.st.busy) begin
        case (lk_reg.act)
          CMD_CMD_WRITE_ENABLE: begin
            sy_next.st.write_enable_latch = 1'b1;
          end
          CMD_CMD_WRITE_DISABLE: begin
            sy_next.st.write_enable_latch = 1'b0;
          end
          CMD_CMD_STATUS_WRITE: begin
            if (sy_reg.st.write_enable_latch &&
                (wp_s || !sy_reg.st.protect_pin_enable)) begin
              sy_next.st.protect_pin_enable = lk_reg.din[SR_PEN_BIT];
              sy_next.st.block_protect_hi   = lk_reg.din[SR_BPH_BIT];
              sy_next.st.block_protect_lo   = lk_reg.din[SR_BPL_BIT];
              tmr_start                     = 1'b1;
            end
          end
          CMD_WRITE: begin
            if (sy_reg.st.write_enable_latch &&
                !secf_blocked({sy_reg.st.block_protect_hi, sy_reg.st.block_protect_lo},
                              lk_reg.addr[MEM_AW-1:0])) begin
              sy_next.wr.valid = 1'b1;
              sy_next.wr.addr  = lk_reg.addr[MEM_AW-1:0];
              sy_next.wr.data  = lk_reg.din;
              tmr_start        = 1'b1;
            end
          end
          default: begin
            sy_next.seq_seen = seq_s;
          end
        endcase
      end
    end
    // back to write disable once the cycle ends
    if (tmr_done) begin
      sy_next.st.write_enable_latch = 1'b0;
    end
    sy_next.st.busy = tmr_busy | tmr_start;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sy_reg    <= '0;
      sy_reg.st <= '{protect_pin_enable: PEN_RST, block_protect_hi: BP_RST[1],
                     block_protect_lo: BP_RST[0], default: 1'b0};
    end else begin
      sy_reg <= sy_next;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  // hold floats the pin at once; the flop keeps the bit for resume
  assign so          = out_reg.so;
  assign so_oe_n     = out_reg.oe_n | ~hold_n;
  assign mem_rd_addr = lk_reg.rd_addr;
  assign mem_wr      = sy_reg.wr;
  assign status      = sy_reg.st;

endmodule // secf_frontend
`default_nettype wire

// >>> testbench/secf_fe_properties.sv
// Purpose: port level checks of the serial memory front end
// Assumes: wp_n steady around frames; WRITE_CYC shortened in simulation
// Notes:   every check samples on sys_clk, sck is only looked at as a level
`timescale 1ns/100ps
`default_nettype none

module secf_fe_properties
  import secf_pkg::*;
#(
  parameter int WRITE_CYC = WRITE_CYCLES
) (
  // clocks and reset
  input wire logic              sys_clk,
  input wire logic              rst,
  input wire logic              sck,
  // serial pins
  input wire logic              cs_n,
  input wire logic              si,
  input wire logic              hold_n,
  input wire logic              wp_n,
  input wire logic              so,
  input wire logic              so_oe_n,
  // array side and status
  input wire logic [MEM_AW-1:0] mem_rd_addr,
  input wire logic [7:0]        mem_rd_data,
  input wire secf_mem_wr_t      mem_wr,
  input wire secf_status_t      status
);
  localparam int BUSY_MAX = WRITE_CYC + 1;
  int busy_cnt;

  // ----------------------------------------
  // helper logic
  // ----------------------------------------
  // counter instead of a long repetition, keeps the tools fast
  always_ff @(posedge sys_clk) begin
    if (rst || !status.busy)
      busy_cnt <= 0;
    else
      busy_cnt <= busy_cnt + 1;
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  // ----------------------------------------
  // properties
  // ----------------------------------------
  sequence s_cycle_start; $rose(status.busy); endsequence
  sequence s_stat_start; $rose(status.busy) && !mem_wr.valid; endsequence

  property p_float_idle; cs_n |-> so_oe_n; endproperty
  a_float_idle: assert property (p_float_idle) else $error("output driven while deselected");
  property p_hold_float; !hold_n |-> so_oe_n; endproperty
  a_hold_float: assert property (p_hold_float) else $error("output driven during pause");
  property p_so_falling; !so_oe_n && !$past(so_oe_n) && $changed(so) |-> !sck; endproperty
  a_so_falling: assert property (p_so_falling) else $error("output moved off the falling edge");
  property p_busy_len; $fell(status.busy) |-> busy_cnt == BUSY_MAX; endproperty
  a_busy_len: assert property (p_busy_len) else $error("write cycle length wrong");
  property p_busy_bound; status.busy |-> busy_cnt < BUSY_MAX; endproperty
  a_busy_bound: assert property (p_busy_bound) else $error("write cycle overran");
  property p_wr_latch; mem_wr.valid |-> $rose(status.busy) && $past(status.write_enable_latch); endproperty
  a_wr_latch: assert property (p_wr_latch) else $error("array write without enable latch");
  property p_latch_drop; $fell(status.busy) |-> ##[0:2] !status.write_enable_latch; endproperty
  a_latch_drop: assert property (p_latch_drop) else $error("latch kept after write cycle");
  property p_quiet_busy; status.busy |=> !mem_wr.valid; endproperty
  a_quiet_busy: assert property (p_quiet_busy) else $error("write accepted while busy");
  property p_bits_frozen;
    status.busy |=> $stable({status.protect_pin_enable, status.block_protect_hi, status.block_protect_lo});
  endproperty
  a_bits_frozen: assert property (p_bits_frozen) else $error("status bits moved while busy");
  property p_stat_guard;
    s_stat_start |-> $past(status.write_enable_latch) && ($past(wp_n) || !$past(status.protect_pin_enable));
  endproperty
  a_stat_guard: assert property (p_stat_guard) else $error("protected status write went ahead");
  c_cycle: cover property (s_cycle_start);
endmodule // secf_fe_properties

bind secf_frontend secf_fe_properties #(.WRITE_CYC(WRITE_CYC)) u_props (
  .sys_clk(sys_clk), .rst(rst), .sck(sck), .cs_n(cs_n), .si(si), .hold_n(hold_n), .wp_n(wp_n),
  .so(so), .so_oe_n(so_oe_n), .mem_rd_addr(mem_rd_addr), .mem_rd_data(mem_rd_data),
  .mem_wr(mem_wr), .status(status));
`default_nettype wire

// >>> testbench/secf_host_model.sv
// Purpose: serial host that frames sessions toward the front end
// Assumes: 32 ns link period, modes 0 and 3 only
// Notes:   sck stands still between frames; si shows no stale bit after a frame
`timescale 1ns/100ps
`default_nettype none

module secf_host_model (
  // serial pins toward the device
  output logic      sck,
  output logic      cs_n,
  output logic      si,
  output logic      hold_n,
  input  wire logic so_pin
);
  // idle levels
  initial begin
    // pins leave unknown after time zero so chip select gives a real edge
    #1;
    cs_n = 1'b1;
    sck = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
    hold_n = 1'b1;
  end

  // one session of n bits, msb first; bit hb gets a hold pause with stray clocks
  task automatic frame(input int n, input logic [39:0] tx, input bit mode3, input int hb,
                       output logic [39:0] rx);
    rx = '0;
    sck = mode3;
    #16 cs_n = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      sck = 1'b0;
      if (i == hb) begin
        hold_n = 1'b0;
        si = ~si;
        repeat (2) begin
          #16 sck = 1'b1;
          #16 sck = 1'b0;
        end
        hold_n = 1'b1;
      end
      si = tx[i];
      #16 sck = 1'b1;
      rx = {rx[38:0], so_pin};
      #16;
    end
    sck = mode3;
    #16 cs_n = 1'b1;
    si = ~si;
    #40;
  endtask
endmodule // secf_host_model
`default_nettype wire

// >>> testbench/tb_secf_frontend.sv
// Purpose: self-checking bench of the serial memory front end
// Assumes: array answers a fixed pattern of its address
// Notes:   array writes checked from a queue by a separate monitor
`timescale 1ns/100ps
`default_nettype none

module tb_secf_frontend;
  import secf_pkg::*;
  localparam int WCYC = 600;  // long enough to fit a read during the cycle
  logic              sys_clk = 1'b0;
  logic              rst = 1'b0;
  logic              wp_n = 1'b1;
  wire logic         sck, cs_n, si, hold_n, so_pin;
  logic              so, so_oe_n;
  logic [MEM_AW-1:0] mem_rd_addr;
  logic [7:0]        mem_rd_data;
  secf_mem_wr_t      mem_wr;
  secf_status_t      status;
  int                mismatches = 0;
  int                compares = 0;
  int                cycles = 0;
  logic [31:0]       rng = 32'h7AA3;
  logic [39:0]       rx;
  logic [21:0]       exp_q[$];

  // ----------------------------------------
  // clock, array, pin and instances
  // ----------------------------------------
  always #2.5 sys_clk = ~sys_clk;
  // released so pin reads the inverse so a stale bit cannot pass
  assign so_pin = so_oe_n ? ~so : so;
  assign mem_rd_data = mem_rd_addr[7:0] ^ 8'hA5;

  secf_frontend #(.WRITE_CYC(WCYC)) uut (
    .sys_clk(sys_clk), .rst(rst), .sck(sck), .cs_n(cs_n), .si(si), .hold_n(hold_n), .wp_n(wp_n),
    .so(so), .so_oe_n(so_oe_n), .mem_rd_addr(mem_rd_addr), .mem_rd_data(mem_rd_data),
    .mem_wr(mem_wr), .status(status));
  secf_host_model host (.sck(sck), .cs_n(cs_n), .si(si), .hold_n(hold_n), .so_pin(so_pin));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] nxt(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    nxt = x ^ (x << 5);
  endfunction

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask

  task automatic cmd(input logic [7:0] op, input bit m3);
    host.frame(8, {32'h0, op}, m3, -1, rx);
  endtask

  task automatic rd_stat(input logic [7:0] exp, input bit m3);
    host.frame(16, {24'h0, OPC_STAT_RD, 8'h00}, m3, -1, rx);
    chk({8'h00, rx[7:0]}, {8'h00, exp});
  endtask

  // bounded wait for the write cycle to end
  task automatic wait_idle;
    repeat (WCYC + 20) @(negedge sys_clk);
    chk({15'h0, status.busy}, 16'h0000);
  endtask

  task automatic final_report;
    if (mismatches == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // ----------------------------------------
  // monitor and watchdog
  // ----------------------------------------
  // each array write must match the oldest note; looked at once settled
  always @(negedge sys_clk) begin
    cycles++;
    if (mem_wr.valid === 1'b1) begin
      compares++;
      if (exp_q.size() == 0 || {mem_wr.addr, mem_wr.data} !== exp_q.pop_front()) begin
        mismatches++;
        $display("BAD %0t array write %h %h not expected", $time, mem_wr.addr, mem_wr.data);
      end
    end
    if (cycles == 30000) begin
      mismatches++;
      final_report();
    end
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    // reset rises after time zero so the link-side flops see an edge
    #1 rst = 1'b1;
    repeat (12) @(negedge sys_clk);
    rst = 1'b0;
    repeat (4) @(negedge sys_clk);
    rd_stat(8'h00, 1'b0);
    host.frame(7, 40'h03, 1'b0, -1, rx);
    cmd(8'h07, 1'b0);
    chk({15'h0, status.write_enable_latch}, 16'h0000);
    for (int m = 0; m < 2; m++) begin
      cmd(OPC_WRITE_EN, m[0]);
      rd_stat(8'h02, m[0]);
      cmd(OPC_WRITE_DIS, m[0]);
      rd_stat(8'h00, m[0]);
    end
    rng = nxt(rng);
    host.frame(32, {8'h00, OPC_MEM_WR, rng[23:0]}, 1'b0, -1, rx);
    cmd(OPC_WRITE_EN, 1'b1);
    rng = nxt(rng);
    exp_q.push_back({rng[21:8], rng[7:0]});
    host.frame(32, {8'h00, OPC_MEM_WR, rng[23:0]}, 1'b0, 12, rx);
    rd_stat(8'hFF, 1'b1);
    host.frame(32, {8'h00, OPC_MEM_WR, ~rng[23:0]}, 1'b0, -1, rx);
    wait_idle();
    rd_stat(8'h00, 1'b0);
    rng = nxt(rng);
    host.frame(40, {OPC_MEM_RD, rng[15:0], 16'h0}, 1'b1, -1, rx);
    chk(rx[15:0], {rng[7:0] ^ 8'hA5, (rng[7:0] + 8'h01) ^ 8'hA5});
    cmd(OPC_WRITE_EN, 1'b0);
    host.frame(16, {24'h0, OPC_STAT_WR, 8'h8C}, 1'b0, -1, rx);
    wait_idle();
    rd_stat(8'h8C, 1'b0);
    @(negedge sys_clk) wp_n = 1'b0;
    cmd(OPC_WRITE_EN, 1'b1);
    host.frame(16, {24'h0, OPC_STAT_WR, 8'h00}, 1'b1, -1, rx);
    rd_stat(8'h8E, 1'b1);
    host.frame(32, {8'h00, OPC_MEM_WR, rng[23:0]}, 1'b0, -1, rx);
    @(negedge sys_clk) wp_n = 1'b1;
    host.frame(16, {24'h0, OPC_STAT_WR, 8'h00}, 1'b0, -1, rx);
    wait_idle();
    rd_stat(8'h00, 1'b0);
    chk(16'(exp_q.size()), 16'h0000);
    final_report();
  end
endmodule // tb_secf_frontend
`default_nettype wire
